// ==== rtl/sos_pkg.sv ====
/*
 * Package for the status output selector: register map, reset values,
 * selection codes and timing constants.
 * Assumes one 100 MHz control clock; no other file defines these names.
 */
package sos_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFF_RELAY_SEL = 8'h00;
    localparam logic [7:0] OFF_DO_SEL = 8'h04;
    localparam logic [7:0] OFF_PULSE_FS = 8'h08;
    localparam logic [7:0] OFF_CFG_BASE = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h44;

    // Indices of the 16-bit threshold and range words from OFF_CFG_BASE
    localparam int CFG_COUNT = 14;
    localparam int CFG_FREQ_LOW = 0;
    localparam int CFG_FREQ_HIGH = 1;
    localparam int CFG_CUR_LOW = 2;
    localparam int CFG_CUR_HIGH = 3;
    localparam int CFG_FEEDBACK_WARN_LOW = 4;
    localparam int CFG_FEEDBACK_WARN_HIGH = 5;
    localparam int CFG_CUR_CEIL = 6;
    localparam int CFG_REF_MIN = 7;
    localparam int CFG_REF_MAX = 8;
    localparam int CFG_FB_MIN = 9;
    localparam int CFG_FB_MAX = 10;
    localparam int CFG_FREQ_MAX = 11;
    localparam int CFG_CUR_INV = 12;
    localparam int CFG_PWR_RATED = 13;

    // Field layout
    localparam int SEL_W = 5;
    localparam int FS_W = 14;
    localparam int VAL_W = 16;
    localparam int ST_RELAY_BIT = 0;
    localparam int ST_DO_BIT = 1;
    localparam int ST_THERM_BIT = 2;
    localparam int CW_RELAY_BIT = 11;
    localparam int CW_DO_BIT = 12;

    // Reset values
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
    localparam logic [FS_W-1:0] PULSE_FS_RESET = 14'h1388;
    localparam logic [VAL_W-1:0] CFG_RESET = 16'h0000;

    // Full-scale pulse frequency limits in Hz
    localparam logic [FS_W-1:0] PULSE_FS_MIN = 14'h0096;
    localparam logic [FS_W-1:0] PULSE_FS_MAX = 14'h2710;

    // Heatsink scaling in degrees C
    localparam logic [VAL_W-1:0] TEMP_ZERO_C = 16'h0014;
    localparam logic [VAL_W-1:0] TEMP_FULL_C = 16'h0064;

    // Clock rate and the half-period count used by the pulse accumulator
    localparam longint CLK_HZ = 100000000;
    localparam logic [25:0] HALF_CLK_HZ = 26'(CLK_HZ / 2);

    // Selection codes
    localparam logic [SEL_W-1:0] C_NONE = 5'h00;
    localparam logic [SEL_W-1:0] C_READY = 5'h01;
    localparam logic [SEL_W-1:0] C_ENABLE_NW = 5'h02;
    localparam logic [SEL_W-1:0] C_RUNNING = 5'h03;
    localparam logic [SEL_W-1:0] C_ON_REF_NW = 5'h04;
    localparam logic [SEL_W-1:0] C_RUN_NW = 5'h05;
    localparam logic [SEL_W-1:0] C_IN_RANGE_NW = 5'h06;
    localparam logic [SEL_W-1:0] C_PREP_LINE_OK = 5'h07;
    localparam logic [SEL_W-1:0] C_ALARM_WARN = 5'h08;
    localparam logic [SEL_W-1:0] C_CUR_CEIL = 5'h09;
    localparam logic [SEL_W-1:0] C_ALARM = 5'h0A;
    localparam logic [SEL_W-1:0] C_ABOVE_F_LOW = 5'h0B;
    localparam logic [SEL_W-1:0] C_BELOW_F_HIGH = 5'h0C;
    localparam logic [SEL_W-1:0] C_ABOVE_I_LOW = 5'h0D;
    localparam logic [SEL_W-1:0] C_BELOW_I_HIGH = 5'h0E;
    localparam logic [SEL_W-1:0] C_ABOVE_FEEDBACK_WARN_LOW = 5'h0F;
    localparam logic [SEL_W-1:0] C_BELOW_FEEDBACK_WARN_HIGH = 5'h10;
    localparam logic [SEL_W-1:0] C_FIELDBUS = 5'h11;
    localparam logic [SEL_W-1:0] C_REVERSE = 5'h12;
    localparam logic [SEL_W-1:0] C_THERMAL = 5'h13;
    localparam logic [SEL_W-1:0] C_LOCAL = 5'h14;
    localparam logic [SEL_W-1:0] C_PULSE_REF = 5'h15;
    localparam logic [SEL_W-1:0] C_F_OUTSIDE = 5'h16;
    localparam logic [SEL_W-1:0] C_I_OUTSIDE = 5'h17;
    localparam logic [SEL_W-1:0] C_FB_OUTSIDE = 5'h18;
    localparam logic [SEL_W-1:0] C_BRAKE = 5'h19;
    localparam logic [SEL_W-1:0] C_RELAY_CW = 5'h1A;
    localparam logic [SEL_W-1:0] C_PULSE_FB = 5'h1A;
    localparam logic [SEL_W-1:0] C_PULSE_FREQ = 5'h1B;
    localparam logic [SEL_W-1:0] C_PULSE_CUR = 5'h1C;
    localparam logic [SEL_W-1:0] C_PULSE_PWR = 5'h1D;
    localparam logic [SEL_W-1:0] C_PULSE_TEMP = 5'h1E;
    localparam logic [SEL_W-1:0] C_DO_CW = 5'h1F;

endpackage

// ==== rtl/sos_status_output_selector.sv ====
/*
 * Status output selector: picks one drive condition for the relay and one
 * condition or proportional pulse train for the 24 V digital output.
 * Assumes drive status and measured values come from logic on hclk; only
 * the thermistor pin is asynchronous. Registers sit on an AHB-Lite slave.
 */
// Decided for this implementation: register access over AHB-Lite and the register offsets.
//
// Summary of operation
// - Relay code 0 (reset default) keeps the relay open always.
// - Nonzero relay code closes contact while chosen condition is true.
// - Code 1: control supplied and drive ready.
// - Code 2: ready, no start command, no warning.
// - Code 3: start command present; code 5 also needs no warning.
// - Code 4: speed matches reference and no warning.
// - Code 7: ready, supplied, no control inputs, line voltage in limits.
// - Code 8: alarm or warning; code 10: alarm only.
// - Code 9: output current above the current ceiling.
// - Codes 11-14: frequency and current compared to low/high thresholds.
// - Codes 15, 16: feedback above low or below high threshold.
// - Codes 22-24: frequency, current, feedback outside their windows.
// - Code 18: active while rotating counter-clockwise.
// - Code 19: temperature limit exceeded or thermistor overtemperature.
// - Code 20: active in local operation.
// - Relay code 26 follows control word bit 11.
// - Code 17 only with fieldbus profile; code 25 drives the brake.
// - Digital output accepts codes 0-20 and 22-25 like the relay.
// - Digital output high while its selected status condition holds.
// - Code 21: pulses proportional to reference between min and max.
// - Codes 26-29: pulses from feedback, frequency, current, power.
// - Code 30: heatsink 20 to 100 C; code 31 follows bit 12.
// - Full-scale pulse frequency 150 to 10000 Hz, default 5000 Hz.
`timescale 1ns/1ps

module sos_status_output_selector (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Drive condition flags, hclk domain
    input wire logic ctrl_supplied,
    input wire logic drive_ready,
    input wire logic start_cmd,
    input wire logic warning_active,
    input wire logic alarm_active,
    input wire logic speed_on_ref,
    input wire logic speed_in_range,
    input wire logic control_inputs_active,
    input wire logic line_voltage_ok,
    input wire logic rotate_ccw,
    input wire logic temp_limit_exceeded,
    input wire logic local_mode,
    input wire logic fieldbus_profile,
    input wire logic fieldbus_relay_bit,
    input wire logic external_brake_drive,
    input wire logic [15:0] ctrl_word,
    // Thermistor digital input pin, asynchronous
    input wire logic thermistor_pin,
    // Measured values, hclk domain
    input wire logic [15:0] out_freq,
    input wire logic [15:0] out_current,
    input wire logic [15:0] feedback_val,
    input wire logic [15:0] reference_val,
    input wire logic [15:0] out_power,
    input wire logic [7:0] heatsink_temp,
    // Status outputs
    output logic relay_out,
    output logic do_out
);

    logic [sos_pkg::SEL_W-1:0] relay_function_select_reg;
    logic [sos_pkg::SEL_W-1:0] do_function_select_reg;
    logic [sos_pkg::FS_W-1:0] pulse_output_full_scale_reg;
    logic [sos_pkg::VAL_W-1:0] cfg_reg [sos_pkg::CFG_COUNT];
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_next;
    logic th_s1_reg, th_s2_reg, th_s3_reg, thermal_pin_reg;
    logic relay_reg, do_reg;
    logic relay_next, do_status_next;
    logic pulse_mode;
    logic [15:0] p_val, p_lo, p_hi, p_num, p_span;
    logic [43:0] acc_reg;
    logic [43:0] acc_sum, acc_limit;
    logic pulse_reg;
    logic [sos_pkg::FS_W-1:0] fs_clamped;
    localparam logic [25:0] HALF_CLK = sos_pkg::HALF_CLK_HZ;
    // Named thresholds for readability
    logic [15:0] f_low, f_high, i_low, i_high, feedback_warn_low, feedback_warn_high, i_ceil;
    assign f_low = cfg_reg[sos_pkg::CFG_FREQ_LOW];
    assign f_high = cfg_reg[sos_pkg::CFG_FREQ_HIGH];
    assign i_low = cfg_reg[sos_pkg::CFG_CUR_LOW];
    assign i_high = cfg_reg[sos_pkg::CFG_CUR_HIGH];
    assign feedback_warn_low = cfg_reg[sos_pkg::CFG_FEEDBACK_WARN_LOW];
    assign feedback_warn_high = cfg_reg[sos_pkg::CFG_FEEDBACK_WARN_HIGH];
    assign i_ceil = cfg_reg[sos_pkg::CFG_CUR_CEIL];
    // Zero wait states and OKAY only; both come from flip-flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Address phase capture for writes; data arrives one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    // Write value clamped into the legal full-scale range
    always_comb begin
        fs_clamped = hwdata[sos_pkg::FS_W-1:0];
        if (hwdata[31:sos_pkg::FS_W] != '0 || hwdata[sos_pkg::FS_W-1:0] > sos_pkg::PULSE_FS_MAX) begin
            fs_clamped = sos_pkg::PULSE_FS_MAX;
        end else if (hwdata[sos_pkg::FS_W-1:0] < sos_pkg::PULSE_FS_MIN) begin
            fs_clamped = sos_pkg::PULSE_FS_MIN;
        end
    end

    // Selector and full-scale registers; unmapped writes are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            relay_function_select_reg <= sos_pkg::SEL_RESET;
            do_function_select_reg <= sos_pkg::SEL_RESET;
            pulse_output_full_scale_reg <= sos_pkg::PULSE_FS_RESET;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == sos_pkg::OFF_RELAY_SEL) begin
                relay_function_select_reg <= hwdata[sos_pkg::SEL_W-1:0];
            end
            if (wr_addr_reg == sos_pkg::OFF_DO_SEL) begin
                do_function_select_reg <= hwdata[sos_pkg::SEL_W-1:0];
            end
            if (wr_addr_reg == sos_pkg::OFF_PULSE_FS) begin
                pulse_output_full_scale_reg <= fs_clamped;
            end
        end
    end

    // One threshold or range word per entry
    generate
        for (genvar i = 0; i < sos_pkg::CFG_COUNT; i++) begin : g_cfg
            localparam logic [7:0] CFG_OFF = 8'(sos_pkg::OFF_CFG_BASE + 4 * i);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cfg_reg[i] <= sos_pkg::CFG_RESET;
                end else if (wr_pend_reg && wr_addr_reg == CFG_OFF) begin
                    cfg_reg[i] <= hwdata[sos_pkg::VAL_W-1:0];
                end
            end
        end
    endgenerate

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_next = 32'h0000_0000;
        case (haddr)
            sos_pkg::OFF_RELAY_SEL: rd_next = {27'h0, relay_function_select_reg};
            sos_pkg::OFF_DO_SEL: rd_next = {27'h0, do_function_select_reg};
            sos_pkg::OFF_PULSE_FS: rd_next = {18'h0, pulse_output_full_scale_reg};
            sos_pkg::OFF_STATUS: rd_next = {29'h0, thermal_pin_reg, do_reg, relay_reg};
            default: begin
                if (haddr >= sos_pkg::OFF_CFG_BASE && haddr < sos_pkg::OFF_STATUS && haddr[1:0] == 2'b00) begin
                    rd_next = {16'h0, cfg_reg[4'((haddr - sos_pkg::OFF_CFG_BASE) >> 2)]};
                end
            end
        endcase
    end

    // Read data registered at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            hrdata_reg <= rd_next;
        end
    end
    assign hrdata = hrdata_reg;

    // Thermistor pin: three stages, change accepted when stages 2 and 3 agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            th_s1_reg <= 1'b0;
            th_s2_reg <= 1'b0;
            th_s3_reg <= 1'b0;
            thermal_pin_reg <= 1'b0;
        end else begin
            th_s1_reg <= thermistor_pin;
            th_s2_reg <= th_s1_reg;
            th_s3_reg <= th_s2_reg;
            if (th_s2_reg == th_s3_reg) begin
                thermal_pin_reg <= th_s3_reg;
            end
        end
    end

    // Status condition for one code, strict comparisons throughout
    function automatic logic status_cond(input logic [sos_pkg::SEL_W-1:0] code);
        logic r;
        r = 1'b0;
        case (code)
            sos_pkg::C_READY: r = ctrl_supplied && drive_ready;
            sos_pkg::C_ENABLE_NW: r = drive_ready && !start_cmd && !warning_active;
            sos_pkg::C_RUNNING: r = start_cmd;
            sos_pkg::C_ON_REF_NW: r = speed_on_ref && !warning_active;
            sos_pkg::C_RUN_NW: r = start_cmd && !warning_active;
            sos_pkg::C_IN_RANGE_NW: r = start_cmd && speed_in_range && !warning_active;
            sos_pkg::C_PREP_LINE_OK: begin
                r = drive_ready && ctrl_supplied && !control_inputs_active && line_voltage_ok;
            end
            sos_pkg::C_ALARM_WARN: r = alarm_active || warning_active;
            sos_pkg::C_CUR_CEIL: r = out_current > i_ceil;
            sos_pkg::C_ALARM: r = alarm_active;
            sos_pkg::C_ABOVE_F_LOW: r = out_freq > f_low;
            sos_pkg::C_BELOW_F_HIGH: r = out_freq < f_high;
            sos_pkg::C_ABOVE_I_LOW: r = out_current > i_low;
            sos_pkg::C_BELOW_I_HIGH: r = out_current < i_high;
            sos_pkg::C_ABOVE_FEEDBACK_WARN_LOW: r = feedback_val > feedback_warn_low;
            sos_pkg::C_BELOW_FEEDBACK_WARN_HIGH: r = feedback_val < feedback_warn_high;
            sos_pkg::C_FIELDBUS: r = fieldbus_profile && fieldbus_relay_bit;
            sos_pkg::C_REVERSE: r = rotate_ccw;
            sos_pkg::C_THERMAL: r = temp_limit_exceeded || thermal_pin_reg;
            sos_pkg::C_LOCAL: r = local_mode;
            sos_pkg::C_F_OUTSIDE: r = out_freq < f_low || out_freq > f_high;
            sos_pkg::C_I_OUTSIDE: r = out_current < i_low || out_current > i_high;
            sos_pkg::C_FB_OUTSIDE: r = feedback_val < feedback_warn_low || feedback_val > feedback_warn_high;
            sos_pkg::C_BRAKE: r = external_brake_drive;
            default: r = 1'b0;
        endcase
        return r;
    endfunction
    // Relay: code 0 and unknown codes keep the contact open
    always_comb begin
        if (relay_function_select_reg == sos_pkg::C_RELAY_CW) begin
            relay_next = ctrl_word[sos_pkg::CW_RELAY_BIT];
        end else begin
            relay_next = status_cond(relay_function_select_reg);
        end
    end
    // Digital output status; codes 21, 26-31 handled apart; a process, so flags read in the function wake it
    always_comb begin
        do_status_next = status_cond(do_function_select_reg);
    end
    // Pulse source and its scaling range
    always_comb begin
        pulse_mode = 1'b1;
        p_val = reference_val;
        p_lo = cfg_reg[sos_pkg::CFG_REF_MIN];
        p_hi = cfg_reg[sos_pkg::CFG_REF_MAX];
        case (do_function_select_reg)
            sos_pkg::C_PULSE_REF: p_val = reference_val;
            sos_pkg::C_PULSE_FB: begin
                p_val = feedback_val;
                p_lo = cfg_reg[sos_pkg::CFG_FB_MIN];
                p_hi = cfg_reg[sos_pkg::CFG_FB_MAX];
            end
            sos_pkg::C_PULSE_FREQ: begin
                p_val = out_freq;
                p_lo = 16'h0000;
                p_hi = cfg_reg[sos_pkg::CFG_FREQ_MAX];
            end
            sos_pkg::C_PULSE_CUR: begin
                p_val = out_current;
                p_lo = 16'h0000;
                p_hi = cfg_reg[sos_pkg::CFG_CUR_INV];
            end
            sos_pkg::C_PULSE_PWR: begin
                p_val = out_power;
                p_lo = 16'h0000;
                p_hi = cfg_reg[sos_pkg::CFG_PWR_RATED];
            end
            sos_pkg::C_PULSE_TEMP: begin
                p_val = {8'h00, heatsink_temp};
                p_lo = sos_pkg::TEMP_ZERO_C;
                p_hi = sos_pkg::TEMP_FULL_C;
            end
            default: pulse_mode = 1'b0;
        endcase
    end
    // Clamp into the range; an empty range gives no pulses at all
    always_comb begin
        p_span = (p_hi > p_lo) ? p_hi - p_lo : 16'h0000;
        if (p_span == 16'h0000 || p_val <= p_lo) begin
            p_num = 16'h0000;
        end else if (p_val >= p_hi) begin
            p_num = p_span;
        end else begin
            p_num = p_val - p_lo;
        end
        acc_sum = acc_reg + 44'(p_num) * 44'(pulse_output_full_scale_reg);
        acc_limit = 44'(p_span) * 44'(HALF_CLK); // Widened first so the products cannot wrap
    end
    // Phase accumulator avoids a divider: toggles at num*fs/span Hz * 2
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_reg <= 44'h000_0000_0000;
            pulse_reg <= 1'b0;
        end else if (!pulse_mode || p_span == 16'h0000) begin
            acc_reg <= 44'h000_0000_0000;
            pulse_reg <= 1'b0;
        end else if (acc_sum >= acc_limit) begin
            acc_reg <= acc_sum - acc_limit;
            pulse_reg <= !pulse_reg;
        end else begin
            acc_reg <= acc_sum;
        end
    end

    // Output flops; pulse path adds one stage behind the toggle flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            relay_reg <= 1'b0;
            do_reg <= 1'b0;
        end else begin
            relay_reg <= relay_next;
            if (do_function_select_reg == sos_pkg::C_DO_CW) begin
                do_reg <= ctrl_word[sos_pkg::CW_DO_BIT];
            end else if (pulse_mode) begin
                do_reg <= pulse_reg;
            end else begin
                do_reg <= do_status_next;
            end
        end
    end
    assign relay_out = relay_reg;
    assign do_out = do_reg;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_relay_none;
        relay_function_select_reg == sos_pkg::C_NONE |=> !relay_out;
    endproperty
    a_relay_none: assert property (p_relay_none) else $error("relay active with code 0");
    property p_relay_ready;
        relay_function_select_reg == sos_pkg::C_READY |=> relay_out == $past(ctrl_supplied && drive_ready);
    endproperty
    a_relay_ready: assert property (p_relay_ready) else $error("relay unit ready mismatch");
    property p_relay_enable;
        relay_function_select_reg == sos_pkg::C_ENABLE_NW
            |=> relay_out == $past(drive_ready && !start_cmd && !warning_active);
    endproperty
    a_relay_enable: assert property (p_relay_enable) else $error("relay enable mismatch");
    property p_relay_run_nw;
        relay_function_select_reg == sos_pkg::C_RUN_NW && warning_active |=> !relay_out;
    endproperty
    a_relay_run_nw: assert property (p_relay_run_nw) else $error("relay on despite warning");
    property p_relay_alarm;
        relay_function_select_reg == sos_pkg::C_ALARM |=> relay_out == $past(alarm_active);
    endproperty
    a_relay_alarm: assert property (p_relay_alarm) else $error("relay alarm mismatch");
    property p_relay_ceiling;
        relay_function_select_reg == sos_pkg::C_CUR_CEIL && out_current == i_ceil |=> !relay_out;
    endproperty
    a_relay_ceiling: assert property (p_relay_ceiling) else $error("ceiling compare not strict");
    property p_relay_fwin;
        relay_function_select_reg == sos_pkg::C_F_OUTSIDE && out_freq > f_high |=> relay_out;
    endproperty
    a_relay_fwin: assert property (p_relay_fwin) else $error("frequency window miss");
    property p_relay_cw;
        relay_function_select_reg == sos_pkg::C_RELAY_CW |=> relay_out == $past(ctrl_word[11]);
    endproperty
    a_relay_cw: assert property (p_relay_cw) else $error("relay not following bit 11");
    property p_relay_fieldbus;
        relay_function_select_reg == sos_pkg::C_FIELDBUS && !fieldbus_profile |=> !relay_out;
    endproperty
    a_relay_fieldbus: assert property (p_relay_fieldbus) else $error("fieldbus code without profile");
    property p_do_status;
        $stable(do_function_select_reg) && do_function_select_reg == sos_pkg::C_ALARM_WARN
            |=> do_out == $past(alarm_active || warning_active);
    endproperty
    a_do_status: assert property (p_do_status) else $error("digital output status mismatch");
    property p_do_cw;
        do_function_select_reg == sos_pkg::C_DO_CW |=> do_out == $past(ctrl_word[12]);
    endproperty
    a_do_cw: assert property (p_do_cw) else $error("digital output not following bit 12");
    property p_temp_cold;
        do_function_select_reg == sos_pkg::C_PULSE_TEMP && heatsink_temp <= 8'h14 |=> $stable(pulse_reg);
    endproperty
    a_temp_cold: assert property (p_temp_cold) else $error("pulses below 20 C");
    property p_fs_range;
        pulse_output_full_scale_reg >= sos_pkg::PULSE_FS_MIN && pulse_output_full_scale_reg <= sos_pkg::PULSE_FS_MAX;
    endproperty
    a_fs_range: assert property (p_fs_range) else $error("full scale out of range");

endmodule

// ==== verification/sos_pulse_counter.sv ====
/* Partner model: an external counter input wired to the digital output.
   Assumes it samples do_out on hclk, as a fast counter card would. */
`timescale 1ns/1ps
module sos_pulse_counter (
    // Clock and watched terminal
    input wire logic hclk,
    input wire logic do_out,
    // Rising edges seen so far
    output logic [31:0] n_pulse
);
    logic last_reg = 1'b0;
    logic [31:0] cnt_reg = 32'h0;
    // Counts edges only, so the duty cycle of the train does not matter
    always_ff @(posedge hclk) begin
        last_reg <= do_out;
        if (do_out && !last_reg) begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end
    assign n_pulse = cnt_reg;
endmodule

// ==== verification/testbench.sv ====
/* Self-checking bench for the status output selector.
   Assumes a zero-wait AHB-Lite slave and the pulse counter partner. */
`timescale 1ns/1ps
module testbench;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00;
    logic [31:0] hwdata = 32'h0, hrdata, rd, n_pulse;
    logic hreadyout, hresp, relay_out, do_out;
    logic [14:0] flg = 15'h0;
    logic [15:0] cw = 16'h0, fr = 16'h0, cu = 16'h0;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    always #5 hclk = ~hclk;
    // Measured values share buses so no input sits idle
    sos_status_output_selector sos_status_output_selector_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .ctrl_supplied(flg[0]), .drive_ready(flg[1]), .start_cmd(flg[2]), .warning_active(flg[3]),
        .alarm_active(flg[4]), .speed_on_ref(flg[5]), .speed_in_range(flg[6]), .local_mode(flg[11]),
        .control_inputs_active(flg[7]), .line_voltage_ok(flg[8]), .rotate_ccw(flg[9]),
        .temp_limit_exceeded(flg[10]), .fieldbus_profile(flg[12]), .fieldbus_relay_bit(flg[13]),
        .external_brake_drive(flg[14]), .ctrl_word(cw), .thermistor_pin(flg[7]), .out_freq(fr),
        .out_current(cu), .feedback_val(cu), .reference_val(fr), .out_power(cu),
        .heatsink_temp(fr[7:0]), .relay_out, .do_out);
    sos_pulse_counter sos_pulse_counter_i (.hclk, .do_out, .n_pulse);
    // Hang guard, well above the long pulse window
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            close_out;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Single transfer; address held until hready, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // Let the selection and inputs settle, then look at one output
    task automatic stp(input logic d, input logic e);
        repeat (3) @(posedge hclk);
        chk(32'(d ? do_out : relay_out), 32'(e));
    endtask
    task automatic t_reg;
        bus(0, 8'h08, 32'h0);
        chk(rd, 32'h1388);
        bus(1, 8'h08, 32'h5);
        bus(0, 8'h08, 32'h0);
        chk(rd, 32'h0096);
        bus(0, 8'h80, 32'h0);
        chk(rd, 32'h0);
        $display("t_reg done");
    endtask
    task automatic t_tab;
        logic [4:0] c [15] = '{0, 1, 2, 2, 3, 5, 8, 10, 17, 17, 18, 19, 20, 25, 19};
        logic [14:0] m [15] = '{15'h7FFF, 3, 2, 6, 4, 12, 8, 8, 15'h2000, 15'h3000, 15'h200,
            15'h400, 15'h800, 15'h4000, 15'h80};
        logic [14:0] e = 15'b111111001010110;
        for (int i = 0; i < 15; i++) begin
            flg <= m[i];
            bus(1, 8'h00, {27'h0, c[i]});
            stp(0, e[i]);
        end
        $display("t_tab done");
    endtask
    task automatic t_cmp;
        flg <= 15'h0;
        bus(1, 8'h24, 32'h64);
        bus(1, 8'h00, 32'h09);
        cu <= 16'h64;
        stp(0, 0);
        cu <= 16'h65;
        stp(0, 1);
        bus(1, 8'h18, 32'h32);
        bus(1, 8'h00, 32'h17);
        stp(0, 1);
        bus(1, 8'h00, 32'h1A);
        cw <= 16'h0800;
        stp(0, 1);
        $display("t_cmp done");
    endtask
    task automatic t_do;
        bus(1, 8'h04, 32'h1F);
        cw <= 16'h1000;
        stp(1, 1);
        cw <= 16'h0;
        stp(1, 0);
        bus(1, 8'h04, 32'h08);
        flg <= 15'h10;
        stp(1, 1);
        $display("t_do done");
    endtask
    // Full scale 10000 Hz: rises near 5000 and 15000 cycles in
    task automatic t_pulse;
        logic [31:0] n0;
        bus(1, 8'h08, 32'h2710);
        bus(1, 8'h38, 32'h64);
        fr <= 16'h64;
        bus(1, 8'h04, 32'h1B);
        n0 = n_pulse;
        repeat (22000) @(posedge hclk);
        chk(n_pulse - n0, 32'h2);
        $display("t_pulse done");
    endtask
    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reg;
        t_tab;
        t_cmp;
        t_do;
        t_pulse;
        close_out;
    end
endmodule
